// ---- rtl/iev_edge_det.sv ----
/*
  edge detector for one external interrupt pin with polarity select.
  assumes the pin is asynchronous; it is synchronised here by two flip-flops.
*/
`timescale 1ns/1ps
module iev_edge_det (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and selection
  input wire logic pin,
  input wire logic falling_sel,
  // detected edge
  output logic edge_pulse
);
  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  // 1 picks falling edge, 0 rising edge
  always_comb begin
    if (falling_sel) begin
      edge_pulse = last_reg & ~sync2_reg;
    end else begin
      edge_pulse = ~last_reg & sync2_reg;
    end
  end
endmodule

// ---- rtl/iev_pkg.sv ----
/*
  package for the interrupt control / flag status block: offsets, fields, reset values, structs.
  assumes an apb slave with 32-bit data and one register per aligned word.
*/
package iev_pkg;
  localparam logic [11:0] IEV_CTRL_TWO_OFF = 12'h000;
  localparam logic [11:0] IEV_FLAG_ZERO_OFF = 12'h004;
  localparam logic [15:0] IEV_CTRL_TWO_RST = 16'h0000;
  localparam logic [15:0] IEV_FLAG_ZERO_RST = 16'h0000;
  localparam int IEV_ALT_VEC_BIT = 15;
  localparam int IEV_TIMED_DIS_BIT = 14;
  localparam int IEV_EP2_BIT = 2;
  localparam int IEV_EP1_BIT = 1;
  localparam int IEV_EP0_BIT = 0;
  localparam logic [15:0] IEV_CTRL_WR_MASK = 16'h8007;
  localparam logic [15:0] IEV_FLAG_MASK = 16'h3fef;
  localparam int IEV_EXT0_FLAG_BIT = 0;
  localparam int IEV_EXT_NUM = 3;

  // peripheral request pulses, one per flag bit from 1 to 13 except bit 4
  typedef struct packed {
    logic adc_done;
    logic serial_tx;
    logic serial_rx;
    logic spi_event;
    logic spi_fault;
    logic timer_three;
    logic timer_two;
    logic compare_two;
    logic capture_two;
    logic timer_one;
    logic compare_one;
    logic capture_one;
  } iev_periph_req_t;

  typedef struct packed {
    logic alt_vector_table_sel;
    logic [IEV_EXT_NUM-1:0] ext_irq_edge_polarity;
  } iev_ctrl_out_t;
endpackage

// ---- rtl/iev_top.sv ----
/*
  interrupt control register two and flag status register zero behind an apb slave.
  assumes the core supplies a timed-disable level on pclk and peripheral request pulses on pclk.
*/
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module iev_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic timed_disable_in,
  output iev_pkg::iev_ctrl_out_t ctrl_out,
  // interrupt sources
  input wire logic [iev_pkg::IEV_EXT_NUM-1:0] ext_irq_pin,
  input wire iev_pkg::iev_periph_req_t periph_req,
  output logic [15:0] flag_status
);
  import iev_pkg::*;

  logic [15:0] ctrl_two_reg;
  logic [15:0] ctrl_two_next;
  logic [15:0] flag_zero_reg;
  logic [15:0] flag_zero_next;
  logic [15:0] flag_set;
  logic [IEV_EXT_NUM-1:0] ext_edge;
  logic timed_dis_reg;
  logic setup_ph;
  logic wr_ctrl;
  logic wr_flag;
  logic addr_ok;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign setup_ph = psel & ~penable;
  assign addr_ok = hit(paddr, IEV_CTRL_TWO_OFF) | hit(paddr, IEV_FLAG_ZERO_OFF);
  assign wr_ctrl = psel & penable & pready & pwrite & hit(paddr, IEV_CTRL_TWO_OFF);
  assign wr_flag = psel & penable & pready & pwrite & hit(paddr, IEV_FLAG_ZERO_OFF);

  genvar gi;
  generate
    for (gi = 0; gi < IEV_EXT_NUM; gi++) begin : g_ext
      iev_edge_det u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_irq_pin[gi]),
        .falling_sel(ctrl_two_reg[gi]),
        .edge_pulse(ext_edge[gi])
      );
    end
  endgenerate

  // timed-disable status, same clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timed_dis_reg <= 1'b0;
    end else begin
      timed_dis_reg <= timed_disable_in;
    end
  end

  // control register two: writable bits only
  always_comb begin
    ctrl_two_next = ctrl_two_reg;
    if (wr_ctrl) begin
      ctrl_two_next = pwdata[15:0] & IEV_CTRL_WR_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_two_reg <= IEV_CTRL_TWO_RST;
    end else begin
      ctrl_two_reg <= ctrl_two_next;
    end
  end

  // hardware sets; set wins over a software write of 0
  always_comb begin
    flag_set = {2'b00, periph_req.adc_done, periph_req.serial_tx, periph_req.serial_rx,
                periph_req.spi_event, periph_req.spi_fault, periph_req.timer_three,
                periph_req.timer_two, periph_req.compare_two, periph_req.capture_two, 1'b0,
                periph_req.timer_one, periph_req.compare_one, periph_req.capture_one, ext_edge[0]};
    flag_zero_next = flag_zero_reg;
    if (wr_flag) begin
      flag_zero_next = pwdata[15:0];
    end
    flag_zero_next = (flag_zero_next | flag_set) & IEV_FLAG_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_zero_reg <= IEV_FLAG_ZERO_RST;
    end else begin
      flag_zero_reg <= flag_zero_next;
    end
  end

  // apb answer: no wait state, pready and data registered in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~addr_ok;
      if (setup_ph & ~pwrite & hit(paddr, IEV_CTRL_TWO_OFF)) begin
        prdata <= {16'h0000, ctrl_two_reg[15], timed_dis_reg, 11'h000, ctrl_two_reg[2:0]};
      end else if (setup_ph & ~pwrite & hit(paddr, IEV_FLAG_ZERO_OFF)) begin
        prdata <= {16'h0000, flag_zero_reg};
      end else if (setup_ph) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // core-facing outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_out <= '0;
      flag_status <= 16'h0000;
    end else begin
      ctrl_out.alt_vector_table_sel <= ctrl_two_next[IEV_ALT_VEC_BIT];
      ctrl_out.ext_irq_edge_polarity <= ctrl_two_next[IEV_EXT_NUM-1:0];
      flag_status <= flag_zero_next;
    end
  end

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      ctrl_two_reg[13:3] == 11'h000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("control reserved bits set");

  property p_alt_follows;
    @(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> ctrl_out.alt_vector_table_sel == $past(pwdata[15]);
  endproperty
  a_alt_follows: assert property (p_alt_follows) else $error("alt table select not updated");

  property p_std_table;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_two_reg[15] |-> !ctrl_out.alt_vector_table_sel || $past(wr_ctrl);
  endproperty
  a_std_table: assert property (p_std_table) else $error("alt table selected while bit clear");

  property p_timed_dis_read;
    @(posedge pclk) disable iff (!presetn)
      setup_ph && !pwrite && hit(paddr, IEV_CTRL_TWO_OFF) |=> prdata[14] == $past(timed_dis_reg);
  endproperty
  a_timed_dis_read: assert property (p_timed_dis_read) else $error("timed disable status misread");

  property p_timed_dis_nowrite;
    @(posedge pclk) disable iff (!presetn)
      ctrl_two_reg[14] == 1'b0;
  endproperty
  a_timed_dis_nowrite: assert property (p_timed_dis_nowrite) else $error("status bit 14 stored");

  // pin seen two and three edges back, against the selected direction
  property p_pol2;
    @(posedge pclk) disable iff (!presetn)
      ext_edge[2] == ($past(ext_irq_pin[2], 3) == ctrl_two_reg[2] &&
                      $past(ext_irq_pin[2], 2) == !ctrl_two_reg[2]);
  endproperty
  a_pol2: assert property (p_pol2) else $error("external 2 edge direction wrong");

  property p_pol1;
    @(posedge pclk) disable iff (!presetn)
      ext_edge[1] == ($past(ext_irq_pin[1], 3) == ctrl_two_reg[1] &&
                      $past(ext_irq_pin[1], 2) == !ctrl_two_reg[1]);
  endproperty
  a_pol1: assert property (p_pol1) else $error("external 1 edge direction wrong");

  property p_ext0_set;
    @(posedge pclk) disable iff (!presetn)
      ext_edge[0] |=> flag_zero_reg[IEV_EXT0_FLAG_BIT];
  endproperty
  a_ext0_set: assert property (p_ext0_set) else $error("external 0 edge lost");

  property p_req_sets;
    @(posedge pclk) disable iff (!presetn)
      periph_req.adc_done |=> flag_zero_reg[13] ##0 flag_status[13];
  endproperty
  a_req_sets: assert property (p_req_sets) else $error("adc flag not set");

  property p_flag_holes;
    @(posedge pclk) disable iff (!presetn)
      (flag_zero_reg & ~IEV_FLAG_MASK) == 16'h0000;
  endproperty
  a_flag_holes: assert property (p_flag_holes) else $error("flag unused bits set");

  property p_pol0;
    @(posedge pclk) disable iff (!presetn)
      ext_edge[0] == ($past(ext_irq_pin[0], 3) == ctrl_two_reg[0] &&
                      $past(ext_irq_pin[0], 2) == !ctrl_two_reg[0]);
  endproperty
  a_pol0: assert property (p_pol0) else $error("external 0 edge direction wrong");

  // software write lands, a same-cycle hardware set still wins
  property p_flag_write;
    @(posedge pclk) disable iff (!presetn)
      wr_flag |=> flag_zero_reg == (($past(pwdata[15:0]) | $past(flag_set)) & IEV_FLAG_MASK);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write not stored");
endmodule

// ---- tb/iev_partner.sv ----
/*
  core and request-source model driving the block's far-side inputs.
  assumes bench commands change just after a pclk edge.
*/
`timescale 1ns/1ps
module iev_partner
  import iev_pkg::*;
(
  // clock
  input wire logic pclk,
  // bench commands
  input wire logic dis_cmd,
  input wire logic [11:0] req_cmd,
  input wire logic [2:0] pin_cmd,
  // block inputs
  output logic timed_disable_in,
  output iev_pkg::iev_periph_req_t periph_req,
  output logic [2:0] ext_irq_pin
);
  // requests leave one edge after the command
  always @(posedge pclk) begin
    timed_disable_in <= dis_cmd;
    periph_req <= iev_periph_req_t'(req_cmd);
    ext_irq_pin <= pin_cmd;
  end
endmodule

// ---- tb/iev_top_bench.sv ----
/*
  self-checking bench for iev_top over apb.
  assumes zero-wait apb slave and the partner model.
*/
`timescale 1ns/1ps
module iev_top_bench;
  import iev_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dis_cmd = 0;
  logic [11:0] paddr = '0, req_cmd = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, timed_disable_in;
  logic [2:0] pin_cmd = '0, ext_irq_pin;
  logic [15:0] flag_status;
  iev_ctrl_out_t ctrl_out;
  iev_periph_req_t periph_req;
  int fail_count = 0, num_checks = 0;
  always #5 pclk = ~pclk;
  iev_top dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timed_disable_in(timed_disable_in), .ctrl_out(ctrl_out), .ext_irq_pin(ext_irq_pin),
    .periph_req(periph_req), .flag_status(flag_status));
  iev_partner fe(.pclk(pclk), .dis_cmd(dis_cmd), .req_cmd(req_cmd), .pin_cmd(pin_cmd),
    .timed_disable_in(timed_disable_in), .periph_req(periph_req), .ext_irq_pin(ext_irq_pin));
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task ck(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      $display("MISMATCH pready expected 1 seen %b", pready);
      fail_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    ap(1'b0, a, 32'h0000_0000);
    ck(n, e, rd);
  endtask
  task t_ctrl;
    rdc(IEV_CTRL_TWO_OFF, 32'h0000_0000, "ctrl reset");
    ck("no err", 32'h0000_0000, {31'h0, er});
    rdc(IEV_FLAG_ZERO_OFF, 32'h0000_0000, "flag reset");
    ap(1'b1, IEV_CTRL_TWO_OFF, 32'hffff_ffff);
    rdc(IEV_CTRL_TWO_OFF, 32'h0000_8007, "ctrl bits");
    ck("alt sel", 32'h0000_0001, {31'h0, ctrl_out.alt_vector_table_sel});
    ap(1'b1, IEV_CTRL_TWO_OFF, 32'h0000_0000);
    ck("alt clr", 32'h0000_0000, {28'h0, ctrl_out});
    $display("done ctrl");
  endtask
  task t_dis;
    dis_cmd <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc(IEV_CTRL_TWO_OFF, 32'h0000_4000, "disable on");
    dis_cmd <= 1'b0;
    ap(1'b1, IEV_CTRL_TWO_OFF, 32'h0000_4000);
    repeat (2) @(posedge pclk);
    rdc(IEV_CTRL_TWO_OFF, 32'h0000_0000, "disable off");
    $display("done disable");
  endtask
  task t_flag;
    ap(1'b1, IEV_FLAG_ZERO_OFF, 32'hffff_ffff);
    rdc(IEV_FLAG_ZERO_OFF, 32'h0000_3fef, "flag rw");
    ap(1'b1, IEV_FLAG_ZERO_OFF, 32'h0000_0000);
    req_cmd <= 12'hfff;
    @(posedge pclk);
    req_cmd <= 12'h000;
    repeat (3) @(posedge pclk);
    ck("flag set", 32'h0000_3fee, {16'h0, flag_status});
    ap(1'b1, IEV_FLAG_ZERO_OFF, 32'h0000_0000);
    $display("done flags");
  endtask
  task t_pin;
    for (int p = 1; p >= 0; p--) begin
      // park the pins at the level from which the wrong edge starts
      pin_cmd <= {3{~p[0]}};
      repeat (8) @(posedge pclk);
      ck("idle edge", 32'h0000_0000, {31'h0, flag_status[0]});
      ap(1'b1, IEV_CTRL_TWO_OFF, {29'h0, {3{p[0]}}});
      ck("polarity", {29'h0, {3{p[0]}}}, {29'h0, ctrl_out.ext_irq_edge_polarity});
      pin_cmd <= {3{p[0]}};
      repeat (8) @(posedge pclk);
      ck("wrong edge", 32'h0000_0000, {31'h0, flag_status[0]});
      pin_cmd <= {3{~p[0]}};
      repeat (8) @(posedge pclk);
      ck("right edge", 32'h0000_0001, {31'h0, flag_status[0]});
      ap(1'b1, IEV_FLAG_ZERO_OFF, 32'h0000_0000);
    end
    $display("done pins");
  endtask
  task t_bad;
    ap(1'b1, 12'h008, 32'hffff_ffff);
    ck("err", 32'h0000_0001, {31'h0, er});
    rdc(IEV_CTRL_TWO_OFF, 32'h0000_0000, "bad write ignored");
    rdc(12'h00c, 32'h0000_0000, "unmapped data");
    ck("err rd", 32'h0000_0001, {31'h0, er});
    $display("done unmapped");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_ctrl();
    t_dis();
    t_flag();
    t_pin();
    t_bad();
    test_done();
  end
endmodule
